// >>> design/typec_port_pkg.sv
// Shared types and constants for the Type-C source port control block
package typec_port_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_VIEW = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h0C;

  localparam int EV_W = 4;
  localparam int EV_ATTACH = 0;
  localparam int EV_DETACH = 1;
  localparam int EV_LOAD_RISE = 2;
  localparam int EV_LOAD_FALL = 3;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
  localparam logic [EV_W-1:0] STATUS_RESET = 4'h0;
  localparam logic CONTROL_RESET = 1'b1;
  localparam int CTRL_VCONN_ALLOW = 0;

  localparam int DEBOUNCE_CYCLES_DEF = 2000;
  localparam int DEB_CNT_W = 16;

  localparam logic [1:0] ADV_DEFAULT = 2'h0;
  localparam logic [1:0] ADV_MEDIUM = 2'h1;
  localparam logic [1:0] ADV_HIGH = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_DIS = 3'h1,
    ST_UNATT = 3'h2,
    ST_DEB = 3'h3,
    ST_ATT = 3'h4
  } port_state_e;

  // Comparator outputs, already qualified
  typedef struct packed {
    logic cc1_rd;
    logic cc1_ra;
    logic cc2_rd;
    logic cc2_ra;
  } cc_sense_s;

  typedef struct packed {
    logic supply_ok;
    logic enable;
    cc_sense_s cc;
    logic over_load;
    logic adv_level;
    logic adv_high;
    logic orient_pin;
    logic attach_pin;
    logic heavy_pin;
  } pin_in_s;

  // Layout of the read-only view register
  typedef struct packed {
    logic [18:0] zero;
    logic [2:0] pins;
    logic [1:0] adv;
    logic heavy;
    logic vconn2;
    logic vconn1;
    logic vbus;
    logic reversed;
    logic [2:0] state;
  } view_reg_s;

endpackage : typec_port_pkg

// >>> design/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q, meta_d;
  logic [WIDTH-1:0] sync_q, sync_d;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : pin_sync

// >>> design/typec_source_port_control.sv
// Type-C source port control: start-up, attach watch, switches, flags, AXI
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Contract
// - Orientation flag released while no sink is attached.
// - Sink on CC1 leaves orientation released; sink on CC2 pulls it low.
// - Enable low opens both switches, releases flags, stops CC watching.
// - Enable high turns the port on and starts normal work.
// - Enable is sampled only once the chip supply clears lockout.
// - After start-up both CC pins are watched for a sink.
// - Main switch closes only after the full attach debounce time.
// - Ra on the unused CC pin gets VCONN after attach.
// - Load detect works only with both advertisement selects high.
// - Load above threshold pulls the heavy-load flag low.
// - Load back below threshold releases the heavy-load flag.
// - Level high, high-select low advertises medium current.
// - Attach flag low while a sink is attached, else released.
// - VBUS is removed once the sink detaches.
module typec_source_port_control #(
  parameter int DEBOUNCE_CYCLES = typec_port_pkg::DEBOUNCE_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [typec_port_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [typec_port_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic supply_ok_in,
  input wire logic enable_in,
  input wire typec_port_pkg::cc_sense_s cc_in,
  input wire logic over_load_in,
  input wire logic adv_level_sel,
  input wire logic adv_high_sel,
  input wire logic orientation_flag_n_i,
  output logic orientation_flag_n_o,
  output logic orientation_flag_n_oe,
  input wire logic attach_flag_n_i,
  output logic attach_flag_n_o,
  output logic attach_flag_n_oe,
  input wire logic heavy_load_flag_n_i,
  output logic heavy_load_flag_n_o,
  output logic heavy_load_flag_n_oe,
  output logic vbus_switch_on,
  output logic vconn_cc1_on,
  output logic vconn_cc2_on,
  output logic cc_monitor_on,
  output logic [1:0] adv_current,
  output logic irq
);

  localparam logic [typec_port_pkg::DEB_CNT_W-1:0] DEB_LAST =
    typec_port_pkg::DEB_CNT_W'(DEBOUNCE_CYCLES - 1);

  if (DEBOUNCE_CYCLES < 1 ||
      DEBOUNCE_CYCLES > (1 << typec_port_pkg::DEB_CNT_W)) begin : g_chk
    $error("DEBOUNCE_CYCLES out of range for the debounce counter");
  end

  // Every pin passes two flops before any logic reads it
  typec_port_pkg::pin_in_s raw, s;
  logic [$bits(typec_port_pkg::pin_in_s)-1:0] sync_vec;

  always_comb begin
    raw.supply_ok = supply_ok_in;
    raw.enable = enable_in;
    raw.cc = cc_in;
    raw.over_load = over_load_in;
    raw.adv_level = adv_level_sel;
    raw.adv_high = adv_high_sel;
    raw.orient_pin = orientation_flag_n_i;
    raw.attach_pin = attach_flag_n_i;
    raw.heavy_pin = heavy_load_flag_n_i;
  end

  pin_sync #(
    .WIDTH($bits(typec_port_pkg::pin_in_s))
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(raw),
    .sync_out(sync_vec)
  );

  assign s = typec_port_pkg::pin_in_s'(sync_vec);

  // Port state machine
  typec_port_pkg::port_state_e state_q, state_d;
  logic rev_q, rev_d;
  logic [typec_port_pkg::DEB_CNT_W-1:0] cnt_q, cnt_d;
  logic sink1, sink2, side_ok;

  // Rd on both pins is an accessory, not a sink
  assign sink1 = s.cc.cc1_rd && !s.cc.cc2_rd;
  assign sink2 = s.cc.cc2_rd && !s.cc.cc1_rd;
  assign side_ok = rev_q ? sink2 : sink1;

  always_comb begin
    state_d = state_q;
    rev_d = rev_q;
    cnt_d = cnt_q;
    if (!s.supply_ok) begin
      state_d = typec_port_pkg::ST_OFF;
    end else if (state_q != typec_port_pkg::ST_OFF && !s.enable) begin
      state_d = typec_port_pkg::ST_DIS;
    end else begin
      unique case (state_q)
        typec_port_pkg::ST_OFF: begin
          // Enable is looked at only after lockout clears
          state_d = s.enable ? typec_port_pkg::ST_UNATT
                             : typec_port_pkg::ST_DIS;
        end
        typec_port_pkg::ST_DIS: begin
          state_d = typec_port_pkg::ST_UNATT;
        end
        typec_port_pkg::ST_UNATT: begin
          if (sink1 || sink2) begin
            state_d = typec_port_pkg::ST_DEB;
            rev_d = sink2;
            cnt_d = '0;
          end
        end
        typec_port_pkg::ST_DEB: begin
          if (!side_ok) begin
            state_d = typec_port_pkg::ST_UNATT;
          end else if (cnt_q == DEB_LAST) begin
            state_d = typec_port_pkg::ST_ATT;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        typec_port_pkg::ST_ATT: begin
          if (!side_ok) begin
            state_d = typec_port_pkg::ST_UNATT;
          end
        end
        default: begin
          state_d = typec_port_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= typec_port_pkg::ST_OFF;
      rev_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      rev_q <= rev_d;
      cnt_q <= cnt_d;
    end
  end

  // Pin drive, registered from the next state and the advertisement selects
  logic ctrl_q, ctrl_d;
  logic vbus_q, vbus_d, vc1_q, vc1_d, vc2_q, vc2_d;
  logic orient_q, orient_d, attach_q, attach_d;
  logic heavy_q, heavy_d, mon_q, mon_d, load_en;
  logic [1:0] adv_q, adv_d;

  always_comb begin
    vbus_d = state_d == typec_port_pkg::ST_ATT;
    mon_d = state_d == typec_port_pkg::ST_UNATT ||
            state_d == typec_port_pkg::ST_DEB || vbus_d;
    vc1_d = vbus_d && rev_d && s.cc.cc1_ra && ctrl_q;
    vc2_d = vbus_d && !rev_d && s.cc.cc2_ra && ctrl_q;
    orient_d = vbus_d && rev_d;
    attach_d = vbus_d;
    load_en = s.adv_level && s.adv_high && mon_d;
    heavy_d = load_en && s.over_load && vbus_d;
    if (!s.adv_level) begin
      adv_d = typec_port_pkg::ADV_DEFAULT;
    end else if (s.adv_high) begin
      adv_d = typec_port_pkg::ADV_HIGH;
    end else begin
      adv_d = typec_port_pkg::ADV_MEDIUM;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbus_q <= 1'b0;
      vc1_q <= 1'b0;
      vc2_q <= 1'b0;
      orient_q <= 1'b0;
      attach_q <= 1'b0;
      heavy_q <= 1'b0;
      mon_q <= 1'b0;
      adv_q <= typec_port_pkg::ADV_DEFAULT;
    end else begin
      vbus_q <= vbus_d;
      vc1_q <= vc1_d;
      vc2_q <= vc2_d;
      orient_q <= orient_d;
      attach_q <= attach_d;
      heavy_q <= heavy_d;
      mon_q <= mon_d;
      adv_q <= adv_d;
    end
  end

  assign vbus_switch_on = vbus_q;
  assign vconn_cc1_on = vc1_q;
  assign vconn_cc2_on = vc2_q;
  assign cc_monitor_on = mon_q;
  assign adv_current = adv_q;
  // Open-drain pins only ever pull low
  assign orientation_flag_n_o = 1'b0;
  assign orientation_flag_n_oe = orient_q;
  assign attach_flag_n_o = 1'b0;
  assign attach_flag_n_oe = attach_q;
  assign heavy_load_flag_n_o = 1'b0;
  assign heavy_load_flag_n_oe = heavy_q;

  // AXI4-Lite slave and interrupt status
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [typec_port_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [typec_port_pkg::EV_W-1:0] status_q, status_d, mask_q, mask_d;
  logic [typec_port_pkg::EV_W-1:0] events;
  logic irq_q, irq_d, do_write, do_read;
  typec_port_pkg::view_reg_s view;

  assign awready = !aw_hold_q && !bvalid_q;
  assign wready = !w_hold_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign do_read = arvalid && arready;

  always_comb begin
    events = '0;
    events[typec_port_pkg::EV_ATTACH] = vbus_d && !vbus_q;
    events[typec_port_pkg::EV_DETACH] = vbus_q && !vbus_d;
    events[typec_port_pkg::EV_LOAD_RISE] = heavy_d && !heavy_q;
    events[typec_port_pkg::EV_LOAD_FALL] = heavy_q && !heavy_d;
    view.zero = '0;
    view.pins = {s.orient_pin, s.attach_pin, s.heavy_pin};
    view.adv = adv_q;
    view.heavy = heavy_q;
    view.vconn2 = vc2_q;
    view.vconn1 = vc1_q;
    view.vbus = vbus_q;
    view.reversed = rev_q;
    view.state = state_q;
  end

  always_comb begin
    aw_hold_d = aw_hold_q || (awvalid && awready);
    w_hold_d = w_hold_q || (wvalid && wready);
    awaddr_d = (awvalid && awready) ? awaddr : awaddr_q;
    wdata_d = (wvalid && wready) ? wdata : wdata_q;
    wstrb_d = (wvalid && wready) ? wstrb : wstrb_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    status_d = status_q;
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = typec_port_pkg::RESP_OKAY;
      if (awaddr_q == typec_port_pkg::ADDR_MASK) begin
        if (wstrb_q[0]) begin
          mask_d = wdata_q[typec_port_pkg::EV_W-1:0];
        end
      end else if (awaddr_q == typec_port_pkg::ADDR_CONTROL) begin
        if (wstrb_q[0]) begin
          ctrl_d = wdata_q[typec_port_pkg::CTRL_VCONN_ALLOW];
        end
      end else if (awaddr_q != typec_port_pkg::ADDR_STATUS &&
                   awaddr_q != typec_port_pkg::ADDR_VIEW) begin
        bresp_d = typec_port_pkg::RESP_SLVERR;
      end
    end
    rvalid_d = rvalid_q && !rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d = typec_port_pkg::RESP_OKAY;
      unique case (araddr)
        typec_port_pkg::ADDR_STATUS: rdata_d = 32'(status_q);
        typec_port_pkg::ADDR_MASK: rdata_d = 32'(mask_q);
        typec_port_pkg::ADDR_VIEW: rdata_d = view;
        typec_port_pkg::ADDR_CONTROL: rdata_d = 32'(ctrl_q);
        default: begin
          rdata_d = 32'h0;
          rresp_d = typec_port_pkg::RESP_SLVERR;
        end
      endcase
      // Clear on read; a same-cycle event survives
      if (araddr == typec_port_pkg::ADDR_STATUS) begin
        status_d = '0;
      end
    end
    status_d = status_d | events;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= typec_port_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= typec_port_pkg::RESP_OKAY;
      status_q <= typec_port_pkg::STATUS_RESET;
      mask_q <= typec_port_pkg::MASK_RESET;
      ctrl_q <= typec_port_pkg::CONTROL_RESET;
      irq_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      status_q <= status_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
      irq_q <= irq_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  orient_idle_a: assert property (
    !vbus_q |-> !orientation_flag_n_oe)
    else $error("orientation driven while unattached");
  orient_side_a: assert property (
    state_q == typec_port_pkg::ST_UNATT && state_d == typec_port_pkg::ST_DEB
    |=> rev_q == $past(sink2))
    else $error("orientation side latched wrong");
  disable_off_a: assert property (
    s.supply_ok && !s.enable |=> !vbus_switch_on && !vconn_cc1_on &&
      !vconn_cc2_on && !attach_flag_n_oe && !heavy_load_flag_n_oe &&
      !orientation_flag_n_oe && !cc_monitor_on)
    else $error("disable did not shut the port");
  enable_on_a: assert property (
    state_q == typec_port_pkg::ST_DIS && s.supply_ok && s.enable
    |=> state_q == typec_port_pkg::ST_UNATT ##0 cc_monitor_on)
    else $error("enable did not start the port");
  lockout_a: assert property (
    !s.supply_ok |=> state_q == typec_port_pkg::ST_OFF && !cc_monitor_on)
    else $error("port active under lockout");
  debounce_a: assert property (
    $rose(vbus_switch_on) |-> $past(cnt_q) == DEB_LAST &&
      $past(state_q, 2) == typec_port_pkg::ST_DEB)
    else $error("switch closed before debounce end");
  vconn_side_a: assert property (
    vconn_cc1_on |-> vbus_switch_on && rev_q && !vconn_cc2_on)
    else $error("VCONN on the wrong pin");
  load_gate_a: assert property (
    !(s.adv_level && s.adv_high) |=> !heavy_load_flag_n_oe)
    else $error("load flag without high advertisement");
  load_high_a: assert property (
    s.over_load && s.adv_level && s.adv_high &&
    state_d == typec_port_pkg::ST_ATT |=> heavy_load_flag_n_oe)
    else $error("heavy load not flagged");
  load_low_a: assert property (
    !s.over_load |=> !heavy_load_flag_n_oe)
    else $error("load flag held below threshold");
  adv_medium_a: assert property (
    s.adv_level && !s.adv_high |=>
      adv_current == typec_port_pkg::ADV_MEDIUM)
    else $error("medium advertisement missing");
  attach_flag_a: assert property (
    attach_flag_n_oe == (state_q == typec_port_pkg::ST_ATT))
    else $error("attach flag disagrees with state");
  detach_off_a: assert property (
    state_q == typec_port_pkg::ST_ATT && !side_ok |=> !vbus_switch_on)
    else $error("VBUS held after detach");
  release_all_a: assert property (
    $fell(vbus_switch_on) |-> !vconn_cc1_on && !vconn_cc2_on &&
      !orientation_flag_n_oe && !attach_flag_n_oe)
    else $error("outputs left driven after detach");

  attach_rev_c: cover property (
    $rose(vbus_switch_on) && orientation_flag_n_oe);
  vconn_c: cover property ($rose(vconn_cc2_on));
  heavy_c: cover property ($rose(heavy_load_flag_n_oe));
  irq_c: cover property ($rose(irq));

endmodule : typec_source_port_control

// >>> sim/sink_model.sv
// Sink device and cable model on the CC pins and the switched output
`timescale 1ns/100ps
module sink_model #(
  parameter int ADJ_CYCLES = 40
) (
  input wire logic aclk,
  input wire logic [1:0] attach_pin_sel,
  input wire logic cable_marked,
  input wire logic draw_heavy,
  input wire logic vbus_switch_on,
  input wire logic [1:0] adv_current,
  output typec_port_pkg::cc_sense_s cc_in,
  output logic over_load_in
);
  int adj_q;
  always_ff @(posedge aclk) begin
    if (adv_current == typec_port_pkg::ADV_HIGH) begin
      adj_q <= 0;
    end else if (adj_q < ADJ_CYCLES) begin
      adj_q <= adj_q + 1;
    end
  end
  // Rd on the sink pin, Ra of a marked cable on the other one
  always_comb begin
    cc_in.cc1_rd = attach_pin_sel[0];
    cc_in.cc2_rd = attach_pin_sel[1];
    cc_in.cc1_ra = cable_marked && attach_pin_sel == 2'h2;
    cc_in.cc2_ra = cable_marked && attach_pin_sel == 2'h1;
  end
  // No current without a closed switch; heavy draw stops after a lower offer
  assign over_load_in = draw_heavy && vbus_switch_on &&
                        adj_q < ADJ_CYCLES;
endmodule : sink_model

// >>> sim/typec_source_port_control_tb_top.sv
// Self-checking bench for the Type-C source port control block
`timescale 1ns/100ps
module typec_source_port_control_tb_top;
  localparam int DEB = 8;
  localparam int LIMIT = 5000;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [typec_port_pkg::ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  // Response readies stay high, so back-to-back calls never re-drive them
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic arvalid = 1'b0, rready = 1'b1, supply_ok_in = 1'b0;
  logic enable_in = 1'b1, adv_level_sel = 1'b1, adv_high_sel = 1'b1;
  logic [1:0] attach_pin_sel = 2'h0;
  logic cable_marked = 1'b0, draw_heavy = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, over_load_in, irq;
  logic [1:0] bresp, rresp, adv_current;
  typec_port_pkg::cc_sense_s cc_in;
  logic orientation_flag_n_o, orientation_flag_n_oe, attach_flag_n_o;
  logic attach_flag_n_oe, heavy_load_flag_n_o, heavy_load_flag_n_oe;
  logic vbus_switch_on, vconn_cc1_on, vconn_cc2_on, cc_monitor_on;
  logic orient_pin, attach_pin, heavy_pin;
  int err_count = 0, n_checks = 0, cycles = 0;
  // Pull-ups on the open-drain flags
  assign orient_pin = orientation_flag_n_oe ? orientation_flag_n_o : 1'b1;
  assign attach_pin = attach_flag_n_oe ? attach_flag_n_o : 1'b1;
  assign heavy_pin = heavy_load_flag_n_oe ? heavy_load_flag_n_o : 1'b1;

  typec_source_port_control #(
    .DEBOUNCE_CYCLES(DEB)
  ) i_typec_source_port_control (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .supply_ok_in(supply_ok_in), .enable_in(enable_in), .cc_in(cc_in),
    .over_load_in(over_load_in), .adv_level_sel(adv_level_sel),
    .adv_high_sel(adv_high_sel), .orientation_flag_n_i(orient_pin),
    .orientation_flag_n_o(orientation_flag_n_o),
    .orientation_flag_n_oe(orientation_flag_n_oe),
    .attach_flag_n_i(attach_pin), .attach_flag_n_o(attach_flag_n_o),
    .attach_flag_n_oe(attach_flag_n_oe), .heavy_load_flag_n_i(heavy_pin),
    .heavy_load_flag_n_o(heavy_load_flag_n_o),
    .heavy_load_flag_n_oe(heavy_load_flag_n_oe),
    .vbus_switch_on(vbus_switch_on), .vconn_cc1_on(vconn_cc1_on),
    .vconn_cc2_on(vconn_cc2_on), .cc_monitor_on(cc_monitor_on),
    .adv_current(adv_current), .irq(irq)
  );

  sink_model i_sink_model (
    .aclk(aclk), .attach_pin_sel(attach_pin_sel), .cable_marked(cable_marked),
    .draw_heavy(draw_heavy), .vbus_switch_on(vbus_switch_on),
    .adv_current(adv_current), .cc_in(cc_in), .over_load_in(over_load_in)
  );

  always #25 aclk = ~aclk;

  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : axi_read

  // Counts falling edges until the switch is seen closed: one past latency
  task automatic wait_vbus(output int n);
    n = 0;
    while (vbus_switch_on !== 1'b1 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
  endtask : wait_vbus

  initial begin
    int n;
    logic [31:0] d;
    logic [1:0] r;
    cyc(10);
    aresetn <= 1'b1;
    cyc(1);
    axi_read(typec_port_pkg::ADDR_MASK, d, r);
    check(d, 32'h0);
    axi_read(typec_port_pkg::ADDR_CONTROL, d, r);
    check(d, 32'h1);
    axi_read(8'h10, d, r);
    check(d, 32'h0);
    check(r, typec_port_pkg::RESP_SLVERR);
    axi_write(8'h10, 32'h1, r);
    check(r, typec_port_pkg::RESP_SLVERR);
    axi_write(typec_port_pkg::ADDR_MASK, 32'hF, r);
    axi_read(typec_port_pkg::ADDR_MASK, d, r);
    check(d, 32'hF);
    $display("test registers done");
    cyc(8);
    check(cc_monitor_on, 1'b0);
    supply_ok_in <= 1'b1;
    cyc(6);
    check(cc_monitor_on, 1'b1);
    check(orient_pin, 1'b1);
    axi_read(typec_port_pkg::ADDR_VIEW, d, r);
    check(d[2:0], 3'h2);
    $display("test start-up done");
    cable_marked <= 1'b1;
    attach_pin_sel <= 2'h1;
    wait_vbus(n);
    // Two sync stages, one state edge, the debounce, then one to observe
    check(n, DEB + 4);
    check(orient_pin, 1'b1);
    check(attach_pin, 1'b0);
    check({vconn_cc1_on, vconn_cc2_on}, 2'h1);
    check(irq, 1'b1);
    axi_read(typec_port_pkg::ADDR_STATUS, d, r);
    check(d, 32'h1);
    check(irq, 1'b0);
    $display("test attach done");
    check(adv_current, typec_port_pkg::ADV_HIGH);
    draw_heavy <= 1'b1;
    cyc(5);
    check(heavy_pin, 1'b0);
    draw_heavy <= 1'b0;
    cyc(5);
    check(heavy_pin, 1'b1);
    // Partner flag drops high select while the sink still draws heavily
    adv_high_sel <= 1'b0;
    draw_heavy <= 1'b1;
    cyc(6);
    check(adv_current, typec_port_pkg::ADV_MEDIUM);
    check(heavy_pin, 1'b1);
    draw_heavy <= 1'b0;
    adv_high_sel <= 1'b1;
    cyc(5);
    axi_read(typec_port_pkg::ADDR_STATUS, d, r);
    check(d, 32'hC);
    $display("test load detect done");
    axi_write(typec_port_pkg::ADDR_MASK, 32'h0, r);
    attach_pin_sel <= 2'h0;
    cyc(5);
    check({vbus_switch_on, vconn_cc2_on, attach_pin}, 3'h1);
    check(irq, 1'b0);
    axi_read(typec_port_pkg::ADDR_STATUS, d, r);
    check(d, 32'h2);
    $display("test detach done");
    axi_write(typec_port_pkg::ADDR_CONTROL, 32'h0, r);
    attach_pin_sel <= 2'h2;
    cyc(5);
    check({orient_pin, attach_pin}, 2'h3);
    wait_vbus(n);
    check(orient_pin, 1'b0);
    check(vconn_cc1_on, 1'b0);
    axi_write(typec_port_pkg::ADDR_CONTROL, 32'h1, r);
    cyc(2);
    check(vconn_cc1_on, 1'b1);
    $display("test reversed plug done");
    enable_in <= 1'b0;
    cyc(5);
    check({vbus_switch_on, vconn_cc1_on, vconn_cc2_on, orientation_flag_n_oe,
        attach_flag_n_oe, heavy_load_flag_n_oe, cc_monitor_on}, 7'h0);
    enable_in <= 1'b1;
    cyc(5);
    check(cc_monitor_on, 1'b1);
    wait_vbus(n);
    check(vbus_switch_on, 1'b1);
    $display("test enable done");
    attach_pin_sel <= 2'h0;
    cyc(5);
    attach_pin_sel <= 2'h3;
    cyc(DEB + 10);
    check(vbus_switch_on, 1'b0);
    $display("test both Rd done");
    summarize();
  end
endmodule : typec_source_port_control_tb_top
